// ==== sim/dbrs_chk.sv ====
// concurrent checks on the reset supervisor's ports
// assumes binding into dbrs_top and one aclk domain
`timescale 1ns/10ps
`default_nettype none
module dbrs_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int HOLD_GND_MS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic button_in_a_n,
  input wire logic button_in_b_n,
  input wire logic supply_ok,
  input wire logic reset_out_high,
  input wire logic reset_out_low_od_o,
  input wire logic reset_out_low_od_oe,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  // ********************************************
  // helper counters
  // ********************************************
  localparam int QUAL = (HOLD_GND_MS - 1) * TICK_CYCLES; // shortest hold
  localparam int LO_MIN = (dbrs_pkg::LOW_SHORT_MS - 1) * TICK_CYCLES;
  localparam int LO_MAX = (dbrs_pkg::LOW_LONG_MS + 1) * TICK_CYCLES;
  localparam int GAP_MIN = (dbrs_pkg::GAP_MS - 1) * TICK_CYCLES;
  int both_r, both_nxt; // cycles with both buttons low
  int lo_r, lo_nxt; // cycles of low output after recovery
  int gap_r, gap_nxt; // cycles with high output idle
  logic seen_r, seen_nxt; // a qualifying hold was seen
  logic oe_q_r, oe_q_nxt; // last low output level
  logic sup_q_r, sup_q_nxt; // last supply level
  // next values; the hold flag is set once per continuous hold
  always_comb begin
    both_nxt = (!button_in_a_n && !button_in_b_n) ? both_r + 1 : 0;
    lo_nxt = (reset_out_low_od_oe && supply_ok) ? lo_r + 1 : 0;
    gap_nxt = reset_out_high ? 0 : gap_r + 1;
    oe_q_nxt = reset_out_low_od_oe;
    sup_q_nxt = supply_ok;
    seen_nxt = seen_r;
    if (both_r == QUAL) begin
      seen_nxt = 1'b1;
    end else if (reset_out_low_od_oe && !oe_q_r && sup_q_r) begin
      seen_nxt = 1'b0;
    end
  end
  // register the helpers; reset clears the counters and hold flag and sets both last levels high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      both_r <= 0;
      lo_r <= 0;
      gap_r <= 0;
      seen_r <= 1'b0;
      oe_q_r <= 1'b1;
      sup_q_r <= 1'b1;
    end else begin
      both_r <= both_nxt;
      lo_r <= lo_nxt;
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
      oe_q_r <= oe_q_nxt;
      sup_q_r <= sup_q_nxt;
    end
  end
  // ********************************************
  // assertions
  // ********************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  od_zero_a: assert property (!reset_out_low_od_o)
    else $error("open-drain data driven high");
  outs_together_a: assert property ($rose(reset_out_high) |-> reset_out_low_od_oe)
    else $error("high output rose alone");
  uv_hold_a: assert property (!supply_ok |=> reset_out_high && reset_out_low_od_oe)
    else $error("outputs free during undervoltage");
  recover_a: assert property ($rose(supply_ok) |-> reset_out_high && reset_out_low_od_oe)
    else $error("outputs free at recovery");
  press_cause_a: assert property ($rose(reset_out_low_od_oe) |-> !$past(supply_ok) || seen_r)
    else $error("reset without qualifying hold");
  low_len_a: assert property ($fell(reset_out_low_od_oe) |-> lo_r >= LO_MIN && lo_r <= LO_MAX)
    else $error("low pulse length out of range");
  gap_a: assert property ($rose(reset_out_high) && $past(supply_ok) |-> gap_r >= GAP_MIN)
    else $error("high pulses too close");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : dbrs_chk
bind dbrs_top dbrs_chk #(.TICK_CYCLES(TICK_CYCLES), .HOLD_GND_MS(HOLD_GND_MS)) dbrs_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .button_in_a_n(button_in_a_n), .button_in_b_n(button_in_b_n),
  .supply_ok(supply_ok), .reset_out_high(reset_out_high), .reset_out_low_od_o(reset_out_low_od_o),
  .reset_out_low_od_oe(reset_out_low_od_oe), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));
`default_nettype wire

// ==== sim/dbrs_far.sv ====
// far side model: two push-buttons and the processor taking reset
// assumes a pull-up on the open-drain reset line
`timescale 1ns/10ps
`default_nettype none
module dbrs_far (
  input wire logic aclk,
  input wire logic reset_out_high,
  input wire logic reset_out_low_od_o,
  input wire logic reset_out_low_od_oe,
  output var logic button_in_a_n,
  output var logic button_in_b_n,
  output logic rst_wire,
  output var int pulses,
  output var int lo_len,
  output var int hi_len
);
  int lo_run; // cycles the processor sees reset low
  int hi_run; // cycles the high reset is seen
  // the pull-up wins unless the device pulls the line
  assign rst_wire = reset_out_low_od_oe ? reset_out_low_od_o : 1'b1;
  // released buttons read high through their pull-ups
  initial begin
    button_in_a_n = 1'b1;
    button_in_b_n = 1'b1;
    pulses = 0;
    lo_run = 0;
    hi_run = 0;
  end
  // processor side: count and measure each reset pulse
  always @(posedge aclk) begin
    if (!rst_wire) begin
      lo_run <= lo_run + 1;
    end else if (lo_run != 0) begin
      lo_len <= lo_run;
      pulses <= pulses + 1;
      lo_run <= 0;
    end
    if (reset_out_high) begin
      hi_run <= hi_run + 1;
    end else if (hi_run != 0) begin
      hi_len <= hi_run;
      hi_run <= 0;
    end
  end
  // press for len cycles, rep times; solo ties button b low meanwhile
  task automatic press(input int len, input int rep, input bit solo);
    int r;
    if (solo) button_in_b_n <= 1'b0;
    for (r = 0; r < rep; r++) begin
      @(posedge aclk);
      button_in_a_n <= 1'b0;
      button_in_b_n <= 1'b0;
      repeat (len) @(posedge aclk);
      button_in_a_n <= 1'b1;
      button_in_b_n <= solo ? 1'b0 : 1'b1;
      repeat (2) @(posedge aclk);
    end
    button_in_b_n <= 1'b1;
  endtask : press
endmodule : dbrs_far
`default_nettype wire

// ==== sim/testbench.sv ====
// bench for the reset supervisor: strap and press table, then
// register access, a longer pulse setting and an undervoltage dip
// assumes the far side model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int T = 4; // cycles per millisecond tick
  typedef struct {logic [1:0] sel; int len; int rep; bit solo; int exp;} dbrs_row_type;
  // strap, press cycles, repeats, single button, expected pulses
  dbrs_row_type rows [10] = '{'{2'h0, 8, 1, 0, 0}, '{2'h0, 16, 1, 0, 1}, '{2'h1, 16, 1, 0, 0},
    '{2'h1, 24, 1, 0, 1}, '{2'h2, 24, 1, 0, 0}, '{2'h2, 32, 1, 0, 1}, '{2'h3, 16, 1, 0, 0},
    '{2'h0, 8, 2, 0, 0}, '{2'h0, 60, 1, 0, 1}, '{2'h0, 16, 1, 1, 1}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [1:0] hold_delay_select = 2'h0;
  logic supply_ok = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic button_in_a_n, button_in_b_n, reset_out_high, od_o, od_oe, rst_wire;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_data;
  int pulses, lo_len, hi_len, p0;
  int fails = 0;
  int checks_done = 0;
  always #4 aclk = ~aclk; // 125 MHz
  dbrs_top #(.TICK_CYCLES(T), .HOLD_GND_MS(3), .HOLD_OPEN_MS(5), .HOLD_VCC_MS(7)) dbrs_top_inst (
    .aclk(aclk), .aresetn(aresetn), .button_in_a_n(button_in_a_n), .button_in_b_n(button_in_b_n),
    .hold_delay_select(hold_delay_select), .supply_ok(supply_ok), .reset_out_high(reset_out_high),
    .reset_out_low_od_o(od_o), .reset_out_low_od_oe(od_oe), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(s_axi_rready));
  dbrs_far dbrs_far_inst (.aclk(aclk), .reset_out_high(reset_out_high), .reset_out_low_od_o(od_o),
    .reset_out_low_od_oe(od_oe), .button_in_a_n(button_in_a_n), .button_in_b_n(button_in_b_n),
    .rst_wire(rst_wire), .pulses(pulses), .lo_len(lo_len), .hi_len(hi_len));
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // compare one value, report and count a mismatch
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // pulse length within one tick of ms ticks, plus edge slack
  task automatic near(input int x, input int ms);
    check(x >= (ms - 1) * T - 2 && x <= (ms + 1) * T + 2, 1);
  endtask : near
  // a wait that ran out ends the run
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      stop_test;
    end
  endtask : guard
  // reset for five cycles with the strap set
  task automatic do_reset(input logic [1:0] sel);
    @(posedge aclk);
    aresetn <= 1'b0;
    hold_delay_select <= sel;
    repeat (5) @(posedge aclk);
    check({reset_out_high, od_oe, od_o}, 3'h6);
    aresetn <= 1'b1;
  endtask : do_reset
  // wait until both resets are released
  task automatic wait_idle;
    int n;
    for (n = 0; n < 3000 && !(rst_wire && !reset_out_high); n++) @(posedge aclk);
    guard(n, 3000);
    @(posedge aclk); // let the far side log the finished pulse
  endtask : wait_idle
  // one register write; address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // bready rises only once the answer is seen, so the answer must stand
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) s_axi_awvalid <= 1'b0;
      if (wready) s_axi_wvalid <= 1'b0;
      if (bvalid && s_axi_bready) break;
      if (bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    resp = bresp;
    guard(n, 50);
  endtask : wr
  // one register read
  task automatic rd(input logic [3:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // rready rises only once the data is seen, so the data must stand
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) s_axi_arvalid <= 1'b0;
      if (rvalid && s_axi_rready) break;
      if (rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    rd_data = rdata;
    resp = rresp;
    guard(n, 50);
  endtask : rd
  // main sequence: table rows, then the hand-written cases
  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i].sel);
      wait_idle;
      p0 = pulses;
      dbrs_far_inst.press(rows[i].len, rows[i].rep, rows[i].solo);
      wait_idle;
      check(pulses - p0, rows[i].exp);
      if (rows[i].exp == 1) begin
        near(lo_len, 210);
        near(hi_len, 15);
      end
    end
    rd(dbrs_pkg::CFG_OFS);
    check(rd_data, 32'h0000000F);
    rd(dbrs_pkg::CNT_OFS);
    check(rd_data, 32'h00000001);
    rd(dbrs_pkg::STAT_OFS);
    check(rd_data, 32'h00000004);
    wr(dbrs_pkg::CFG_OFS, 32'h00010014);
    check(resp, dbrs_pkg::RESP_OKAY);
    rd(dbrs_pkg::CFG_OFS);
    check(rd_data, 32'h00010014);
    rd(4'hC);
    check(resp, dbrs_pkg::RESP_SLVERR);
    dbrs_far_inst.press(16, 1, 0);
    wait_idle;
    near(lo_len, 360);
    near(hi_len, 20);
    // undervoltage dip of twenty cycles
    supply_ok <= 1'b0;
    repeat (10) @(posedge aclk);
    check({reset_out_high, od_oe}, 2'h3);
    repeat (10) @(posedge aclk);
    supply_ok <= 1'b1;
    wait_idle;
    near(lo_len - 20, 360);
    stop_test;
  end
endmodule : testbench
`default_nettype wire

// ==== verilog/dbrs_pkg.sv ====
// constants, states and register map of the dual button reset supervisor
// assumes a 125 MHz aclk and a synchronous active-low aresetn
// How it works
// - both outputs assert after both buttons held
// - strap picks 2 s, 6 s or 10 s
// - short double press gives no pulse
// - high output push-pull, low output open-drain
// - each output times its own pulse
// - low output pulse 210 ms or 360 ms
// - high output pulse length is a setting
// - undervoltage holds both outputs asserted
// - timeouts start after supply recovers, power-up too
// - at least 10 ms between high-pulse intervals; undervoltage asserts the high output even during the rest time
// - low pulse within 140-280 or 240-480 ms
// - no reset effect unless both buttons low
package dbrs_pkg;
  // *****************************************************
  // timing
  // *****************************************************
  localparam int CLK_PERIOD_NS = 8; // aclk period
  localparam int TICK_TIME_NS = 1000000; // one millisecond tick
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int HOLD_GND_S = 2; // strap grounded
  localparam int HOLD_OPEN_S = 6; // strap open
  localparam int HOLD_VCC_S = 10; // strap at supply
  localparam int HOLD_GND_MS = HOLD_GND_S * MS_PER_S;
  localparam int HOLD_OPEN_MS = HOLD_OPEN_S * MS_PER_S;
  localparam int HOLD_VCC_MS = HOLD_VCC_S * MS_PER_S;
  localparam int LOW_SHORT_MS = 210; // low output, base build
  localparam int LOW_LONG_MS = 360; // low output, alternate build
  localparam int HIGH_MS_PER_NF = 15; // high output per 0.001 uF
  localparam int GAP_MS = 10; // rest between high pulses
  localparam int CNT_W = 16; // millisecond counter width
  // *****************************************************
  // strap codes and button states
  // *****************************************************
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_VCC = 2'h2;
  typedef enum logic [1:0] {
    BTN_IDLE = 2'b00, // waiting for a double press
    BTN_HOLD = 2'b01, // both low, counting
    BTN_FIRE = 2'b10, // qualified, waiting to start pulse
    BTN_REL = 2'b11 // waiting for both released
  } dbrs_btn_type;
  // *****************************************************
  // register map
  // *****************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] CNT_OFS = 4'h8;
  localparam int CFG_HI_LSB = 0; // high pulse length in ms
  localparam int CFG_LONG_BIT = 16; // selects the long low pulse
  localparam logic [15:0] CFG_HI_RST = 16'h000F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dbrs_pkg

// ==== verilog/dbrs_top.sv ====
// dual button reset supervisor: hold qualification, two reset
// pulse timers and an AXI4-Lite register slave
// assumes all inputs synchronous to aclk and supply_ok from a
// comparator outside
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dbrs_top #(
  parameter int TICK_CYCLES = dbrs_pkg::TICK_CYCLES,
  parameter int HOLD_GND_MS = dbrs_pkg::HOLD_GND_MS,
  parameter int HOLD_OPEN_MS = dbrs_pkg::HOLD_OPEN_MS,
  parameter int HOLD_VCC_MS = dbrs_pkg::HOLD_VCC_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  // push-buttons and strap
  input wire logic button_in_a_n,
  input wire logic button_in_b_n,
  input wire logic [1:0] hold_delay_select,
  input wire logic supply_ok, // high while supply above threshold
  // reset outputs
  output logic reset_out_high,
  output logic reset_out_low_od_o,
  output logic reset_out_low_od_oe,
  // axi4-lite
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CW = dbrs_pkg::CNT_W;

  // *****************************************************
  // millisecond tick
  // *****************************************************
  logic [31:0] tick_cnt_r; // cycles within the tick
  logic [31:0] tick_cnt_nxt;
  logic tick; // one-cycle pulse each millisecond

  // count cycles up to one tick period
  always_comb begin
    tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // *****************************************************
  // strap capture and button qualification
  // *****************************************************
  logic [1:0] sel_r; // strap caught while in reset
  logic [CW-1:0] hold_lim; // hold delay in ticks
  dbrs_pkg::dbrs_btn_type btn_r, btn_nxt; // press state
  logic [CW-1:0] hold_r, hold_nxt; // ticks held so far
  logic [7:0] press_r, press_nxt; // qualified presses, wraps
  logic both_low; // both buttons pressed
  logic both_high; // both buttons released
  logic fire_take; // pulse start accepted

  // strap is static, so it is only caught during reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= hold_delay_select;
    end
  end

  // hold limit from the strap; unknown code acts as open
  always_comb begin
    unique case (sel_r)
      dbrs_pkg::SEL_GND: hold_lim = CW'(HOLD_GND_MS);
      dbrs_pkg::SEL_VCC: hold_lim = CW'(HOLD_VCC_MS);
      default: hold_lim = CW'(HOLD_OPEN_MS);
    endcase
  end

  // press state machine
  always_comb begin
    both_low = !button_in_a_n && !button_in_b_n;
    both_high = button_in_a_n && button_in_b_n;
    btn_nxt = btn_r;
    hold_nxt = hold_r;
    press_nxt = press_r;
    unique case (btn_r)
      dbrs_pkg::BTN_IDLE: begin
        hold_nxt = '0;
        if (both_low) begin
          btn_nxt = dbrs_pkg::BTN_HOLD;
        end
      end
      dbrs_pkg::BTN_HOLD: begin
        if (!both_low) begin
          // early release: no pulse, start over
          btn_nxt = dbrs_pkg::BTN_IDLE;
          hold_nxt = '0;
        end else if (hold_r >= hold_lim) begin
          btn_nxt = dbrs_pkg::BTN_FIRE;
          press_nxt = press_r + 8'h01;
        end else if (tick) begin
          hold_nxt = hold_r + CW'(1);
        end
      end
      dbrs_pkg::BTN_FIRE: begin
        if (fire_take) begin
          btn_nxt = dbrs_pkg::BTN_REL;
        end
      end
      dbrs_pkg::BTN_REL: begin
        if (both_high) begin
          btn_nxt = dbrs_pkg::BTN_IDLE; // rearm
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_r <= dbrs_pkg::BTN_IDLE;
      hold_r <= '0;
      press_r <= 8'h00;
    end else begin
      btn_r <= btn_nxt;
      hold_r <= hold_nxt;
      press_r <= press_nxt;
    end
  end

  // *****************************************************
  // pulse timers
  // *****************************************************
  logic [CW-1:0] cfg_hi_r; // high pulse length, ms
  logic cfg_long_r; // long low pulse option
  logic hi_act_r, hi_act_nxt; // high output asserted
  logic lo_act_r, lo_act_nxt; // low output asserted
  logic [CW-1:0] hi_cnt_r, hi_cnt_nxt; // high pulse ms left
  logic [CW-1:0] lo_cnt_r, lo_cnt_nxt; // low pulse ms left
  logic [CW-1:0] gap_r, gap_nxt; // rest ms left after high pulse
  logic [CW-1:0] lo_len; // chosen low pulse length

  // each output counts down on its own; undervoltage holds
  // both loaded so counting begins only after recovery
  always_comb begin
    lo_len = cfg_long_r ? CW'(dbrs_pkg::LOW_LONG_MS)
                        : CW'(dbrs_pkg::LOW_SHORT_MS);
    hi_act_nxt = hi_act_r;
    lo_act_nxt = lo_act_r;
    hi_cnt_nxt = hi_cnt_r;
    lo_cnt_nxt = lo_cnt_r;
    gap_nxt = gap_r;
    // a new pulse waits out the rest time and any running pulse
    fire_take = (btn_r == dbrs_pkg::BTN_FIRE) && (gap_r == '0)
                && !hi_act_r && !lo_act_r && supply_ok;
    if (tick && (gap_r != '0)) begin
      gap_nxt = gap_r - CW'(1);
    end
    if (!supply_ok) begin
      // hold both asserted and loaded
      hi_act_nxt = 1'b1;
      lo_act_nxt = 1'b1;
      hi_cnt_nxt = cfg_hi_r;
      lo_cnt_nxt = lo_len;
    end else if (fire_take) begin
      // both assert in the same cycle
      hi_act_nxt = 1'b1;
      lo_act_nxt = 1'b1;
      hi_cnt_nxt = cfg_hi_r;
      lo_cnt_nxt = lo_len;
    end else begin
      // high output: counts only once the rest time is over
      if (hi_act_r && tick && (gap_r == '0)) begin
        if (hi_cnt_r <= CW'(1)) begin
          hi_act_nxt = 1'b0;
          gap_nxt = CW'(dbrs_pkg::GAP_MS);
        end else begin
          hi_cnt_nxt = hi_cnt_r - CW'(1);
        end
      end
      // low output: own fixed length
      if (lo_act_r && tick) begin
        if (lo_cnt_r <= CW'(1)) begin
          lo_act_nxt = 1'b0;
        end else begin
          lo_cnt_nxt = lo_cnt_r - CW'(1);
        end
      end
    end
  end

  // reset leaves both asserted and loaded: power-up pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_act_r <= 1'b1;
      lo_act_r <= 1'b1;
      hi_cnt_r <= dbrs_pkg::CFG_HI_RST;
      lo_cnt_r <= CW'(dbrs_pkg::LOW_SHORT_MS);
      gap_r <= '0;
    end else begin
      hi_act_r <= hi_act_nxt;
      lo_act_r <= lo_act_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
      gap_r <= gap_nxt;
    end
  end

  // push-pull high output, open-drain low output
  always_comb begin
    reset_out_high = hi_act_r;
    reset_out_low_od_o = 1'b0; // only ever pulls low
    reset_out_low_od_oe = lo_act_r; // released when idle
  end

  // *****************************************************
  // axi4-lite slave
  // *****************************************************
  logic aw_got_r, aw_got_nxt; // write address held
  logic w_got_r, w_got_nxt; // write data held
  logic [3:0] awaddr_r, awaddr_nxt; // held write address
  logic [31:0] wdata_r, wdata_nxt; // held write data
  logic [3:0] wstrb_r, wstrb_nxt; // held byte lanes
  logic bvalid_r, bvalid_nxt; // write answer pending
  logic [1:0] bresp_r, bresp_nxt; // write answer code
  logic rvalid_r, rvalid_nxt; // read answer pending
  logic [31:0] rdata_r, rdata_nxt; // read answer data
  logic [1:0] rresp_r, rresp_nxt; // read answer code
  logic [CW-1:0] cfg_hi_nxt;
  logic cfg_long_nxt;
  logic do_wr; // both halves of a write present
  logic [31:0] stat_word; // live status

  // status word: outputs, supply, strap, press state, rest time
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[0] = hi_act_r;
    stat_word[1] = lo_act_r;
    stat_word[2] = supply_ok;
    stat_word[5:4] = sel_r;
    stat_word[9:8] = btn_r;
    stat_word[12] = (gap_r != '0);
  end

  // address and data taken in either order, answer after both
  always_comb begin
    s_axi_awready = !aw_got_r && !bvalid_r;
    s_axi_wready = !w_got_r && !bvalid_r;
    s_axi_arready = !rvalid_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    cfg_hi_nxt = cfg_hi_r;
    cfg_long_nxt = cfg_long_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    do_wr = aw_got_r && w_got_r;
    if (do_wr) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = dbrs_pkg::RESP_OKAY;
      unique case (awaddr_r)
        dbrs_pkg::CFG_OFS: begin
          if (wstrb_r[0]) begin
            cfg_hi_nxt[7:0] = wdata_r[dbrs_pkg::CFG_HI_LSB +: 8];
          end
          if (wstrb_r[1]) begin
            cfg_hi_nxt[15:8] = wdata_r[dbrs_pkg::CFG_HI_LSB + 8 +: 8];
          end
          if (wstrb_r[2]) begin
            cfg_long_nxt = wdata_r[dbrs_pkg::CFG_LONG_BIT];
          end
        end
        dbrs_pkg::STAT_OFS, dbrs_pkg::CNT_OFS: begin
          // read-only, write ignored
        end
        default: bresp_nxt = dbrs_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = dbrs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dbrs_pkg::CFG_OFS: begin
          rdata_nxt = {15'h0000, cfg_long_r, cfg_hi_r};
        end
        dbrs_pkg::STAT_OFS: rdata_nxt = stat_word;
        dbrs_pkg::CNT_OFS: rdata_nxt = {24'h00_0000, press_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = dbrs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    s_axi_bvalid = bvalid_r;
    s_axi_bresp = bresp_r;
    s_axi_rvalid = rvalid_r;
    s_axi_rdata = rdata_r;
    s_axi_rresp = rresp_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
      cfg_hi_r <= dbrs_pkg::CFG_HI_RST;
      cfg_long_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      cfg_hi_r <= cfg_hi_nxt;
      cfg_long_r <= cfg_long_nxt;
    end
  end
endmodule : dbrs_top
`default_nettype wire
